// ### hdl/modem_pkg.sv
// Package: constants shared by the host port modem design.
// Assumes a 250 MHz pclk; the radio side is abstracted to byte streams.
package modem_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned DEFAULT_BAUD = 9600;
  localparam int unsigned MIN_BAUD = 600;
  localparam int unsigned MAX_BAUD = 115200;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam int unsigned BUF_DEPTH = 96;
  localparam int unsigned CTS_ON_LEVEL = (BUF_DEPTH * 66) / 100;
  localparam int unsigned CTS_OFF_LEVEL = (BUF_DEPTH * 33) / 100;
  localparam int unsigned DIV_DEFAULT = (CLK_HZ + DEFAULT_BAUD / 2) / DEFAULT_BAUD;
  localparam int unsigned DIV_MIN = CLK_HZ / MAX_BAUD;
  localparam int unsigned DIV_MAX = CLK_HZ / MIN_BAUD;
  localparam int unsigned DIV_W = 20;
  localparam int unsigned CNT_W = 7;
  // Edges after reset release before the start-up pin sample is taken
  localparam logic [1:0] BOOT_WAIT = 2'h2;
  // APB register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD_DIV = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TX_DATA = 8'h0C;
  localparam logic [7:0] REG_RX_DATA = 8'h10;
  // Control fields
  localparam int unsigned CTRL_FLOW_HW = 0;
  localparam int unsigned CTRL_LINK_UP = 1;
  localparam int unsigned CTRL_LINK_DOWN = 2;
  localparam int unsigned CTRL_PKT_VALID = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [DIV_W-1:0] BAUD_DIV_RESET = 20'h065BA;
  typedef enum logic [1:0] {ST_SHUTDOWN, ST_STANDBY, ST_CONNECTED, ST_CONFIG} mstate_t;
endpackage : modem_pkg

// ### hdl/uart_rx.sv
// Receiver for 8N1 characters from the host line.
// Assumes the line input is already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none
module uart_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [modem_pkg::DIV_W-1:0] div,
  input wire logic line,
  output logic [7:0] data,
  output logic valid
);
  typedef struct packed {
    logic busy;
    logic [3:0] bit_idx;
    logic [modem_pkg::DIV_W-1:0] cnt;
    logic [7:0] shreg;
    logic [7:0] data;
    logic valid;
  } rx_st_t;
  rx_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (!enable) begin
      s_d.busy = 1'b0;
    end else if (!s_q.busy) begin
      if (!line) begin
        s_d.busy = 1'b1;
        s_d.bit_idx = 4'h0;
        s_d.cnt = div >> 1;
      end
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end else begin
      s_d.cnt = div - 1'b1;
      s_d.bit_idx = s_q.bit_idx + 4'h1;
      if (s_q.bit_idx == 4'h0) begin
        if (line) s_d.busy = 1'b0;
      end else if (s_q.bit_idx <= 4'h8) begin
        s_d.shreg = {line, s_q.shreg[7:1]};
      end else begin
        s_d.busy = 1'b0;
        if (line) begin
          s_d.data = s_q.shreg;
          s_d.valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '0;
    else s_q <= s_d;
  end

  assign data = s_q.data;
  assign valid = s_q.valid;
endmodule : uart_rx
`default_nettype wire

// ### hdl/uart_tx.sv
// Transmitter of 8N1 characters toward the host line.
// Assumes the data source holds data until ready is seen with start.
`timescale 1ns/1ps
`default_nettype none
module uart_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [modem_pkg::DIV_W-1:0] div,
  input wire logic start,
  input wire logic [7:0] data,
  output logic ready,
  output logic line
);
  typedef struct packed {
    logic busy;
    logic [3:0] bit_idx;
    logic [modem_pkg::DIV_W-1:0] cnt;
    logic [9:0] shreg;
    logic line;
  } tx_st_t;
  tx_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.busy) begin
      s_d.line = 1'b1;
      if (start) begin
        s_d.busy = 1'b1;
        s_d.shreg = {1'b1, data, 1'b0};
        s_d.bit_idx = 4'h0;
        s_d.cnt = '0;
      end
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end else if (s_q.bit_idx == 4'hA) begin
      s_d.busy = 1'b0;
      s_d.line = 1'b1;
    end else begin
      s_d.line = s_q.shreg[0];
      s_d.shreg = {1'b1, s_q.shreg[9:1]};
      s_d.bit_idx = s_q.bit_idx + 4'h1;
      s_d.cnt = div - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '{busy: 1'b0, bit_idx: 4'h0, cnt: '0, shreg: 10'h3FF, line: 1'b1};
    else s_q <= s_d;
  end

  assign ready = !s_q.busy;
  assign line = s_q.line;
endmodule : uart_tx
`default_nettype wire

// ### hdl/radio_modem_host_port.sv
// Host serial port and connection state control of a radio packet modem.
// Assumes the radio engine is reached through APB registers; pins synchronous-free.
// Contract
// - Host characters are eight data bits, one stop bit, no parity.
// - Baud rate selectable from 600 to 115200, same on both sides.
// - Flow control either by CTS output or none.
// - Run while sleep input low, shut down while it is high, except in configuration mode, which ignores sleep.
// - In shutdown, no serial or radio traffic until sleep is removed.
// - Exactly three normal states: shutdown, standby, connected.
// - Enter standby after power-up and whenever no link is active.
// - Remote connection request in standby moves at once to connected.
// - Host data in standby sends a connection request to the remote.
// - Remote data goes to host on RXD byte for byte, unchanged.
// - The four control inputs are active low; sleep_req is active high here, shutting down while it is high.
// - Indicator outputs are active low; config_mode is active high here, high while in configuration mode.
// - RXD and TXD carry true, non-inverted levels.
// - Force-default input sets host baud to 9600.
// - Config-entry low at reset starts in configuration mode.
// - Reset input resets the whole device to start-up behaviour.
// - Packet-ready indicator asserted while a valid packet is held.
// - 96-byte receive buffer; CTS on at 66 percent, off below 33.
// - Config-entry input sampled only during start-up.
`timescale 1ns/1ps
`default_nettype none
module radio_modem_host_port #(
  parameter int unsigned BUF_DEPTH = modem_pkg::BUF_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txd,
  output logic rxd,
  output logic cts_n,
  input wire logic sleep_req,
  input wire logic setup_n,
  input wire logic default_baud_n,
  output logic packet_ready_indicator_n,
  output logic connect_req,
  output logic config_mode,
  output logic [1:0] state
);
  localparam int unsigned CW = modem_pkg::CNT_W;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic started;
    logic [1:0] boot;
    logic cfg;
    logic force_def;
    logic flow_hw;
    logic link_up;
    logic pkt_valid;
    logic [modem_pkg::DIV_W-1:0] div;
    modem_pkg::mstate_t st;
    logic [CW-1:0] wr;
    logic [CW-1:0] rd;
    logic [CW-1:0] cnt;
    logic cts_n;
    logic connect_req;
    logic [7:0] tx_byte;
    logic tx_pend;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } st_t;
  st_t s_q, s_d;

  logic [7:0] buf_mem [BUF_DEPTH];
  logic [7:0] rx_byte;
  logic rx_valid;
  logic tx_ready;
  logic tx_line;
  logic comm_en;
  logic tx_start;
  logic rx_push;
  logic [modem_pkg::DIV_W-1:0] eff_div;

  function automatic logic [CW-1:0] ptr_inc(input logic [CW-1:0] p);
    if (p == CW'(BUF_DEPTH - 1)) begin
      ptr_inc = '0;
    end else begin
      ptr_inc = p + 1'b1;
    end
  endfunction : ptr_inc

  assign comm_en = (s_q.st != modem_pkg::ST_SHUTDOWN) && s_q.started;
  // Forcing the rate leaves the stored divider untouched; reset reloads it before the next start-up
  assign eff_div = s_q.force_def ? modem_pkg::DIV_W'(modem_pkg::DIV_DEFAULT) : s_q.div;
  assign tx_start = comm_en && s_q.tx_pend && tx_ready;
  // A full buffer drops the byte rather than overwrite the oldest one
  assign rx_push = rx_valid && comm_en && s_q.cnt != CW'(BUF_DEPTH);

  uart_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .enable(comm_en),
    .div(eff_div),
    .line(txd),
    .data(rx_byte),
    .valid(rx_valid)
  );

  uart_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .div(eff_div),
    .start(tx_start),
    .data(s_q.tx_byte),
    .ready(tx_ready),
    .line(tx_line)
  );

  always_comb begin
    logic wr_acc;
    logic rd_acc;
    logic push;
    logic pop;
    wr_acc = psel && penable && !s_q.pready && pwrite;
    rd_acc = psel && penable && !s_q.pready && !pwrite;
    s_d = s_q;
    s_d.sync1 = {sleep_req, setup_n, default_baud_n};
    s_d.sync2 = s_q.sync1;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.connect_req = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    // Start-up sample waits until both synchroniser stages hold the pins
    if (!s_q.started) begin
      if (s_q.boot == modem_pkg::BOOT_WAIT) begin
        s_d.started = 1'b1;
        s_d.cfg = !s_q.sync2[1];
        s_d.force_def = !s_q.sync2[0];
      end else begin
        s_d.boot = s_q.boot + 2'h1;
      end
    end
    // Connection state machine
    case (s_q.st)
      modem_pkg::ST_SHUTDOWN: begin
        if (!s_q.sync2[2]) s_d.st = modem_pkg::ST_STANDBY;
      end
      modem_pkg::ST_STANDBY: begin
        if (s_q.sync2[2]) s_d.st = modem_pkg::ST_SHUTDOWN;
        else if (s_q.link_up) s_d.st = modem_pkg::ST_CONNECTED;
        else if (rx_valid) s_d.connect_req = 1'b1;
      end
      modem_pkg::ST_CONNECTED: begin
        if (s_q.sync2[2]) s_d.st = modem_pkg::ST_SHUTDOWN;
        else if (!s_q.link_up) s_d.st = modem_pkg::ST_STANDBY;
      end
      modem_pkg::ST_CONFIG: begin
        // Sleep is ignored here; only a reset leaves configuration
        s_d.st = modem_pkg::ST_CONFIG;
      end
      default: s_d.st = modem_pkg::ST_STANDBY;
    endcase
    if (!s_q.started && s_q.boot == modem_pkg::BOOT_WAIT && !s_q.sync2[1]) begin
      s_d.st = modem_pkg::ST_CONFIG;
    end
    // Host bytes into the receive buffer; a full buffer drops the byte
    if (rx_push) begin
      push = 1'b1;
    end
    // Cleared before the bus decode so that a packet marked in this cycle survives
    if (tx_start) begin
      s_d.tx_pend = 1'b0;
      s_d.pkt_valid = 1'b0;
    end
    // APB access: one wait state, answer in the cycle after penable rises
    // Writes land at the first access edge; the master holds until pready anyway
    if (wr_acc) begin
      s_d.pready = 1'b1;
      case (paddr)
        modem_pkg::REG_CTRL: begin
          s_d.flow_hw = pwdata[modem_pkg::CTRL_FLOW_HW];
          if (pwdata[modem_pkg::CTRL_LINK_UP]) s_d.link_up = 1'b1;
          if (pwdata[modem_pkg::CTRL_LINK_DOWN]) s_d.link_up = 1'b0;
          if (pwdata[modem_pkg::CTRL_PKT_VALID]) s_d.pkt_valid = 1'b1;
        end
        modem_pkg::REG_BAUD_DIV: begin
          if (pwdata[modem_pkg::DIV_W-1:0] >= modem_pkg::DIV_W'(modem_pkg::DIV_MIN)
              && pwdata[modem_pkg::DIV_W-1:0] <= modem_pkg::DIV_W'(modem_pkg::DIV_MAX))
            s_d.div = pwdata[modem_pkg::DIV_W-1:0];
          else s_d.pslverr = 1'b1;
        end
        modem_pkg::REG_TX_DATA: begin
          // Remote bytes only forwarded while connected and no byte is already pending
          if (s_q.st == modem_pkg::ST_CONNECTED && !s_q.tx_pend) begin
            s_d.tx_byte = pwdata[7:0];
            s_d.tx_pend = 1'b1;
          end else s_d.pslverr = 1'b1;
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end else if (rd_acc) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      case (paddr)
        modem_pkg::REG_CTRL: begin
          s_d.prdata[modem_pkg::CTRL_FLOW_HW] = s_q.flow_hw;
          s_d.prdata[modem_pkg::CTRL_LINK_UP] = s_q.link_up;
          s_d.prdata[modem_pkg::CTRL_PKT_VALID] = s_q.pkt_valid;
        end
        modem_pkg::REG_BAUD_DIV: s_d.prdata[modem_pkg::DIV_W-1:0] = eff_div;
        modem_pkg::REG_STATUS: begin
          s_d.prdata[1:0] = s_q.st;
          s_d.prdata[2] = s_q.cfg;
          s_d.prdata[3] = s_q.force_def;
          s_d.prdata[4] = s_q.tx_pend;
          s_d.prdata[5] = !s_q.cts_n;
          s_d.prdata[14:8] = s_q.cnt;
        end
        modem_pkg::REG_RX_DATA: begin
          // Reading an empty buffer returns zero with bit 8 clear
          if (s_q.cnt != '0) begin
            s_d.prdata[7:0] = buf_mem[s_q.rd];
            s_d.prdata[8] = 1'b1;
            pop = 1'b1;
          end
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end
    // Link loss purges any byte waiting for the host
    if (s_q.st != modem_pkg::ST_CONNECTED) s_d.tx_pend = 1'b0;
    if (push) s_d.wr = ptr_inc(s_q.wr);
    if (pop) s_d.rd = ptr_inc(s_q.rd);
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
    // Hysteresis keeps CTS from chattering near one threshold
    if (!s_q.flow_hw) s_d.cts_n = 1'b1;
    else if (s_d.cnt >= CW'(modem_pkg::CTS_ON_LEVEL)) s_d.cts_n = 1'b0;
    else if (s_d.cnt < CW'(modem_pkg::CTS_OFF_LEVEL)) s_d.cts_n = 1'b1;
  end

  // No reset: entries are only read behind the fill count
  always_ff @(posedge pclk) begin
    if (rx_push) begin
      buf_mem[s_q.wr] <= rx_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      // Synchronisers start at the inactive pin levels
      s_q.sync1 <= 3'h3;
      s_q.sync2 <= 3'h3;
      s_q.flow_hw <= modem_pkg::CTRL_RESET[modem_pkg::CTRL_FLOW_HW];
      s_q.div <= modem_pkg::BAUD_DIV_RESET;
      s_q.st <= modem_pkg::ST_STANDBY;
      s_q.cts_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  logic rxd_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= comm_en ? tx_line : 1'b1;
    end
  end

  logic pri_n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_n_q <= 1'b1;
    end else begin
      pri_n_q <= !s_d.pkt_valid;
    end
  end

  assign rxd = rxd_q;
  assign cts_n = s_q.cts_n;
  assign packet_ready_indicator_n = pri_n_q;
  assign connect_req = s_q.connect_req;
  assign config_mode = s_q.cfg;
  assign state = s_q.st;
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
endmodule : radio_modem_host_port
`default_nettype wire

// ### tb/modem_props.sv
// Checker: pin-level timing relations of the host port modem.
// Assumes the port names of radio_modem_host_port; bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module modem_props #(
  parameter int unsigned BUF_DEPTH = modem_pkg::BUF_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic sleep_req,
  input wire logic connect_req,
  input wire logic config_mode,
  input wire logic [1:0] state
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("late pready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("long pready");
  chk_rst_standby: assert property ($rose(presetn) |-> state == 2'd1)
    else $error("no standby at reset");
  chk_cfg_state: assert property (config_mode == (state == 2'd3))
    else $error("config flag and state differ");
  chk_cfg_hold: assert property (config_mode |=> config_mode)
    else $error("config left without reset");
  // Four samples: two synchroniser stages plus the state register
  chk_sleep_shut: assert property (sleep_req [*4] ##0 !config_mode |-> state == 2'd0)
    else $error("no shutdown");
  chk_req_standby: assert property (connect_req |-> $past(state) == 2'd1)
    else $error("request outside standby");
  chk_link_up: assert property (psel && penable && pready && pwrite
    && paddr == modem_pkg::REG_CTRL && pwdata[1] && !pwdata[2] && state == 2'd1
    && !sleep_req |-> ##[1:2] state == 2'd2) else $error("link up ignored");
  cov_link: cover property (state == 2'd1 ##1 state == 2'd2);
  cov_shut: cover property (state == 2'd0);
  cov_req: cover property (connect_req);
endmodule : modem_props
bind radio_modem_host_port modem_props #(.BUF_DEPTH(BUF_DEPTH)) modem_props_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .sleep_req, .connect_req,
  .config_mode, .state);
`default_nettype wire

// ### tb/host_link_model.sv
// Host serial port model: sends and receives 8N1 characters.
// Assumes idle-high true levels and a bit time of div pclk cycles.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  input wire logic pclk,
  input wire logic rxd,
  output var logic txd
);
  int unsigned div = 2170;
  int frm_err = 0;
  logic [7:0] rx_q[$];
  initial txd = 1'b1;
  // One frame per call; the caller waits, so frames never overlap
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txd <= f[i];
      repeat (div) @(posedge pclk);
    end
  endtask : send
  always begin
    logic [9:0] f;
    @(negedge rxd);
    repeat (div / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      f[i] = rxd;
      repeat (div) @(posedge pclk);
    end
    if (f[0] !== 1'b0 || f[9] !== 1'b1) frm_err++;
    rx_q.push_back(f[8:1]);
  end
endmodule : host_link_model
`default_nettype wire

// ### tb/testbench.sv
// Testbench: bus and serial scenarios for the host port modem.
// Assumes host_link_model on the serial pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, sleep_req, setup_n, default_baud_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, e, txd, rxd, cts_n, pkt_n, connect_req, config_mode;
  logic [1:0] state;
  logic [31:0] seed = 32'h9B987417;
  int num_errors = 0;
  int n_checks = 0;
  int n_conn = 0;
  radio_modem_host_port radio_modem_host_port_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .txd, .rxd, .cts_n, .sleep_req, .setup_n,
    .default_baud_n, .packet_ready_indicator_n(pkt_n), .connect_req, .config_mode, .state);
  host_link_model host_link_model_i (.pclk, .rxd, .txd);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) if (connect_req === 1'b1) n_conn++;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] exp_div(input int unsigned baud);
    return (modem_pkg::CLK_HZ + baud / 2) / baud;
  endfunction : exp_div
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    do begin
      cyc(1);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(3);
  endtask : bus
  task automatic rst(input logic su, input logic db);
    setup_n <= su;
    default_baud_n <= db;
    presetn <= 1'b0;
    cyc(6);
    presetn <= 1'b1;
    // Start-up needs three edges; the long host wait is cut to keep the run short
    cyc(6);
  endtask : rst
  initial begin
    logic [7:0] b;
    int n;
    int unsigned dv;
    {presetn, psel, penable, pwrite, sleep_req, setup_n, default_baud_n} = 7'h03;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc(1);
    rst(1'b1, 1'b0);
    bus(1'b1, modem_pkg::REG_BAUD_DIV, 32'd3000);
    bus(1'b0, modem_pkg::REG_BAUD_DIV, '0);
    chk(r, exp_div(modem_pkg::DEFAULT_BAUD));
    rst(1'b0, 1'b1);
    bus(1'b0, modem_pkg::REG_STATUS, '0);
    chk(r[2:0], 3'h7);
    $display("test 1 done");
    rst(1'b1, 1'b1);
    setup_n <= 1'b0;
    bus(1'b0, modem_pkg::REG_CTRL, '0);
    chk(r[3:0], 4'h1);
    bus(1'b1, modem_pkg::REG_CTRL, 32'h0);
    bus(1'b0, modem_pkg::REG_CTRL, '0);
    chk(r[0], 1'b0);
    chk(cts_n, 1'b1);
    bus(1'b1, 8'h14, '0);
    chk(e, 1'b1);
    bus(1'b1, modem_pkg::REG_TX_DATA, '0);
    chk(e, 1'b1);
    dv = 2170 + (rnd() & 63);
    bus(1'b1, modem_pkg::REG_BAUD_DIV, 32'(dv));
    chk(e, 1'b0);
    bus(1'b1, modem_pkg::REG_BAUD_DIV, 32'(modem_pkg::DIV_MIN - 1));
    chk(e, 1'b1);
    bus(1'b1, modem_pkg::REG_BAUD_DIV, 32'(modem_pkg::DIV_MAX + 1));
    chk(e, 1'b1);
    host_link_model_i.div = dv;
    b = 8'(rnd());
    host_link_model_i.send(b);
    cyc(dv);
    chk(n_conn, 1);
    bus(1'b0, modem_pkg::REG_STATUS, '0);
    chk(r[14:8], 7'h01);
    bus(1'b0, modem_pkg::REG_RX_DATA, '0);
    chk(r[8:0], {1'b1, b});
    chk({config_mode, state}, 3'h1);
    $display("test 2 done");
    bus(1'b1, modem_pkg::REG_CTRL, 32'h3);
    chk(state, 2'd2);
    bus(1'b1, modem_pkg::REG_CTRL, 32'h9);
    chk(pkt_n, 1'b0);
    b = 8'(rnd());
    bus(1'b1, modem_pkg::REG_TX_DATA, 32'(b));
    for (n = 0; n < 30000 && host_link_model_i.rx_q.size() == 0; n++) cyc(1);
    if (n == 30000) begin
      num_errors++;
      close_out();
    end
    chk(host_link_model_i.rx_q.pop_front(), b);
    chk(pkt_n, 1'b1);
    bus(1'b1, modem_pkg::REG_CTRL, 32'h5);
    chk(state, 2'd1);
    sleep_req <= 1'b1;
    cyc(6);
    chk(state, 2'd0);
    host_link_model_i.send(8'(rnd()));
    cyc(dv);
    bus(1'b0, modem_pkg::REG_RX_DATA, '0);
    chk(r[8], 1'b0);
    sleep_req <= 1'b0;
    cyc(6);
    chk(state, 2'd1);
    chk(host_link_model_i.frm_err, 0);
    $display("test 3 done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
